// >>> hdl/frt_pkg.sv
package frt_pkg;

   // ==========================================================================
   // register addresses (byte addresses on the cpu memory bus)
   // ==========================================================================
   localparam logic [15:0] ADDR_MODE    = 16'hFF48;
   localparam logic [15:0] ADDR_CNT_LO  = 16'hFF14;
   localparam logic [15:0] ADDR_CNT_HI  = 16'hFF15;
   localparam logic [15:0] ADDR_CMP_LO  = 16'hFF16;
   localparam logic [15:0] ADDR_CMP_HI  = 16'hFF17;
   localparam logic [15:0] ADDR_CAP_LO  = 16'hFF18;
   localparam logic [15:0] ADDR_CAP_HI  = 16'hFF19;
   localparam logic [15:0] ADDR_PM2     = 16'hFF22;

   // ==========================================================================
   // timer_mode_control fields, and the port 2 direction bit for pin 4
   // ==========================================================================
   localparam int BIT_OUT_EN    = 0;
   localparam int BIT_CLK_LO    = 1;
   localparam int BIT_CLK_HI    = 2;
   localparam int BIT_INV       = 3;
   localparam int BIT_EDGE_LO   = 4;
   localparam int BIT_EDGE_HI   = 5;
   localparam int BIT_OVF       = 6;
   localparam int BIT_OUT_LVL   = 7;
   localparam int BIT_PIN4      = 4;

   localparam logic [1:0] CLK_SEL_FAST = 2'h0;
   localparam logic [1:0] CLK_SEL_SLOW = 2'h1;
   localparam logic [1:0] EDGE_OFF     = 2'h0;
   localparam logic [1:0] EDGE_RISE    = 2'h1;
   localparam logic [1:0] EDGE_FALL    = 2'h2;
   localparam logic [1:0] EDGE_BOTH    = 2'h3;

   // ==========================================================================
   // reset values and timing
   // ==========================================================================
   localparam logic [7:0]  MODE_RST     = 8'h00;
   localparam logic [7:0]  PM2_RST      = 8'hFF;
   localparam logic [15:0] CNT_RST      = 16'h0000;
   localparam logic [15:0] CMP_RST      = 16'hFFFF;
   localparam logic [15:0] CAP_RST      = 16'h0000;
   localparam int          DIV_FAST_W   = 2;
   localparam int          DIV_SLOW_W   = 6;
   localparam int          CAP_LOAD_CLK = 2;

   // ==========================================================================
   // host command set
   // ==========================================================================
   typedef enum logic [2:0] {
      CMD_READ,
      CMD_WRITE,
      CMD_CNT_RD,
      CMD_CAP_RD,
      CMD_CMP_WR
   } frt_cmd_e;

endpackage : frt_pkg

// >>> hdl/frt_bus_if.sv
`timescale 1ns/1ps
interface frt_bus_if (
   input wire logic i_clk_sys,
   input wire logic i_resetn
);
   logic [15:0] addr;
   logic        rd;
   logic        wr;
   logic [7:0]  wdata;
   logic [7:0]  rdata;
   logic        match_irq;

   modport dev (
      input  i_clk_sys, i_resetn, addr, rd, wr, wdata,
      output rdata, match_irq
   );
   modport cpu (
      input  i_clk_sys, i_resetn, rdata, match_irq,
      output addr, rd, wr, wdata
   );
endinterface : frt_bus_if

// >>> hdl/frt_timer_dev.sv
`timescale 1ns/1ps
module frt_timer_dev (
   // cpu side
   frt_bus_if.dev          bus,
   // pins
   input  wire logic       i_capture_trigger_pin,
   input  wire logic       i_port2_pin4_latch,
   output logic            o_timer_output_pin,
   output logic            o_timer_output_pin_oe
);

   // ==========================================================================
   // state
   // ==========================================================================
   logic [frt_pkg::DIV_SLOW_W-1:0] presc_ff;
   logic [15:0]                    free_counter_ff;
   logic [15:0]                    compare_value_ff;
   logic [15:0]                    captured_value_ff;
   logic [15:0]                    rbuf_ff;
   logic                           rbuf_frozen_ff;
   logic [5:0]                     mode_ff;
   logic                           overflow_flag_ff;
   logic                           tout_ff;
   logic [7:0]                     port2_direction_ff;
   logic [2:0]                     cap_sync_ff;
   logic [7:0]                     rdata_ff;
   logic                           match_ff;

   // ==========================================================================
   // decode
   // ==========================================================================
   wire        sel_mode   = (bus.addr == frt_pkg::ADDR_MODE);
   wire        sel_cnt_lo = (bus.addr == frt_pkg::ADDR_CNT_LO);
   wire        sel_cnt_hi = (bus.addr == frt_pkg::ADDR_CNT_HI);
   wire        sel_cmp_lo = (bus.addr == frt_pkg::ADDR_CMP_LO);
   wire        sel_cmp_hi = (bus.addr == frt_pkg::ADDR_CMP_HI);
   wire        sel_cap_lo = (bus.addr == frt_pkg::ADDR_CAP_LO);
   wire        sel_cap_hi = (bus.addr == frt_pkg::ADDR_CAP_HI);
   wire        sel_pm2    = (bus.addr == frt_pkg::ADDR_PM2);
   wire        wr_mode    = bus.wr & sel_mode;
   wire        rd_cnt_lo  = bus.rd & sel_cnt_lo;
   wire        rd_cnt_hi  = bus.rd & sel_cnt_hi;

   wire        out_en     = mode_ff[frt_pkg::BIT_OUT_EN];
   wire        inv_en     = mode_ff[frt_pkg::BIT_INV];
   wire [1:0]  clk_sel    = mode_ff[frt_pkg::BIT_CLK_HI:frt_pkg::BIT_CLK_LO];
   wire [1:0]  edge_sel   = mode_ff[frt_pkg::BIT_EDGE_HI:frt_pkg::BIT_EDGE_LO];

   // ==========================================================================
   // count clock
   // ==========================================================================
   // prescaled count clock
   wire        tick_fast  = &presc_ff[frt_pkg::DIV_FAST_W-1:0];
   wire        tick_slow  = &presc_ff;
   // prohibited select codes simply stop the counter
   wire        tick       = (clk_sel == frt_pkg::CLK_SEL_FAST) ? tick_fast :
                            (clk_sel == frt_pkg::CLK_SEL_SLOW) ? tick_slow : 1'b0;
   wire [15:0] cnt_inc    = free_counter_ff + 16'h0001;
   // match on the value just reached
   wire        nxt_match  = tick & (cnt_inc == compare_value_ff);
   wire        ovf_set    = tick & (&free_counter_ff);
   wire        ovf_sw_clr = wr_mode & ~bus.wdata[frt_pkg::BIT_OVF];

   // ==========================================================================
   // capture edge
   // ==========================================================================
   // compare second and third samples only
   wire        cap_rise   = cap_sync_ff[1] & ~cap_sync_ff[2];
   wire        cap_fall   = ~cap_sync_ff[1] & cap_sync_ff[2];
   wire        cap_hit    = ((edge_sel == frt_pkg::EDGE_RISE) & cap_rise) |
                            ((edge_sel == frt_pkg::EDGE_FALL) & cap_fall) |
                            ((edge_sel == frt_pkg::EDGE_BOTH) & (cap_rise | cap_fall));

   // ==========================================================================
   // read data
   // ==========================================================================
   // level bit shows timer output
   wire [7:0]  mode_rd    = {tout_ff, overflow_flag_ff, mode_ff};
   wire [7:0]  nxt_rdata  = sel_mode   ? mode_rd :
                            sel_cnt_lo ? rbuf_ff[7:0] :
                            sel_cnt_hi ? rbuf_ff[15:8] :
                            sel_cmp_lo ? compare_value_ff[7:0] :
                            sel_cmp_hi ? compare_value_ff[15:8] :
                            sel_cap_lo ? captured_value_ff[7:0] :
                            sel_cap_hi ? captured_value_ff[15:8] :
                            sel_pm2    ? port2_direction_ff : 8'h00;

   // ==========================================================================
   // counter, compare, output
   // ==========================================================================
   always_ff @(posedge bus.i_clk_sys) begin
      if (!bus.i_resetn) begin
         presc_ff         <= '0;
         free_counter_ff  <= frt_pkg::CNT_RST;
         compare_value_ff <= frt_pkg::CMP_RST;
         match_ff         <= 1'b0;
         tout_ff          <= 1'b0;
      end else begin
         presc_ff <= presc_ff + {{(frt_pkg::DIV_SLOW_W-1){1'b0}}, 1'b1};
         // counts on with no stop hold
         if (tick) begin
            free_counter_ff <= cnt_inc;
         end
         if (bus.wr & sel_cmp_lo) begin
            compare_value_ff[7:0] <= bus.wdata;
         end
         if (bus.wr & sel_cmp_hi) begin
            compare_value_ff[15:8] <= bus.wdata;
         end
         match_ff <= nxt_match;
         if (!out_en) begin
            tout_ff <= 1'b0;
         end else if (nxt_match & inv_en) begin
            tout_ff <= ~tout_ff;
         end
      end
   end

   // ==========================================================================
   // control registers
   // ==========================================================================
   always_ff @(posedge bus.i_clk_sys) begin
      if (!bus.i_resetn) begin
         mode_ff            <= frt_pkg::MODE_RST[5:0];
         overflow_flag_ff   <= frt_pkg::MODE_RST[frt_pkg::BIT_OVF];
         port2_direction_ff <= frt_pkg::PM2_RST;
      end else begin
         if (wr_mode) begin
            mode_ff <= bus.wdata[5:0];
         end
         overflow_flag_ff <= ovf_set | (overflow_flag_ff & ~ovf_sw_clr);
         if (bus.wr & sel_pm2) begin
            port2_direction_ff <= bus.wdata;
         end
      end
   end

   // ==========================================================================
   // capture and read buffer
   // ==========================================================================
   always_ff @(posedge bus.i_clk_sys) begin
      if (!bus.i_resetn) begin
         cap_sync_ff       <= 3'h0;
         captured_value_ff <= frt_pkg::CAP_RST;
         rbuf_ff           <= frt_pkg::CNT_RST;
         rbuf_frozen_ff    <= 1'b0;
         rdata_ff          <= 8'h00;
      end else begin
         cap_sync_ff <= {cap_sync_ff[1:0], i_capture_trigger_pin};
         if (cap_hit) begin
            captured_value_ff <= free_counter_ff;
         end
         // track until frozen by low read
         if (!rbuf_frozen_ff && !rd_cnt_lo) begin
            rbuf_ff <= free_counter_ff;
         end
         if (rd_cnt_hi) begin
            rbuf_frozen_ff <= 1'b0;
         end else if (rd_cnt_lo) begin
            rbuf_frozen_ff <= 1'b1;
         end
         if (bus.rd) begin
            rdata_ff <= nxt_rdata;
         end
      end
   end

   // ==========================================================================
   // pin
   // ==========================================================================
   always_ff @(posedge bus.i_clk_sys) begin
      if (!bus.i_resetn) begin
         o_timer_output_pin    <= 1'b0;
         o_timer_output_pin_oe <= 1'b0;
      end else begin
         o_timer_output_pin    <= out_en ? tout_ff : i_port2_pin4_latch;
         o_timer_output_pin_oe <= ~port2_direction_ff[frt_pkg::BIT_PIN4];
      end
   end

   assign bus.rdata     = rdata_ff;
   assign bus.match_irq = match_ff;

endmodule : frt_timer_dev

// >>> hdl/frt_cpu_host.sv
`timescale 1ns/1ps
module frt_cpu_host (
   // timer bus
   frt_bus_if.cpu                 bus,
   // command port
   input  wire logic              i_cmd_valid,
   input  wire frt_pkg::frt_cmd_e i_cmd,
   input  wire logic [15:0]       i_addr,
   input  wire logic [15:0]       i_wdata,
   output logic                   o_busy,
   output logic                   o_done,
   output logic [15:0]            o_rdata,
   // interrupt side
   output logic                   o_irq_mask,
   output logic                   o_irq_seen
);

   typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_STROBE, ST_COLLECT} frt_hst_e;

   // one bus access of a command sequence: last, write, read-to-high, addr, data
   typedef struct packed {
      logic        last;
      logic        we;
      logic        hi;
      logic [15:0] addr;
      logic [7:0]  data;
   } frt_acc_s;

   frt_hst_e          st_ff;
   frt_pkg::frt_cmd_e cmd_ff;
   logic [15:0]       caddr_ff;
   logic [15:0]       cwdata_ff;
   logic [1:0]        step_ff;
   logic [7:0]        shadow_ff;
   logic [15:0]       addr_ff;
   logic              rd_ff;
   logic              wr_ff;
   logic [7:0]        wdata_ff;

   // ==========================================================================
   // command sequences
   // ==========================================================================
   function automatic frt_acc_s frt_step(input frt_pkg::frt_cmd_e cmd,
                                        input logic [1:0] step,
                                        input logic [15:0] addr,
                                        input logic [15:0] wd,
                                        input logic [7:0] sh);
      frt_acc_s a;
      logic [7:0] no_edge;
      logic [7:0] no_inv;
      no_edge = sh;
      no_inv  = sh;
      no_edge[frt_pkg::BIT_EDGE_HI] = 1'b0;
      no_edge[frt_pkg::BIT_EDGE_LO] = 1'b0;
      no_inv[frt_pkg::BIT_INV]      = 1'b0;
      a = '{last: 1'b1, we: 1'b0, hi: 1'b0, addr: addr, data: wd[7:0]};
      unique case (cmd)
         frt_pkg::CMD_READ: a.we = 1'b0;
         frt_pkg::CMD_WRITE: a.we = 1'b1;
         // counter read as a low-high pair
         frt_pkg::CMD_CNT_RD: begin
            a.last = step[0];
            a.hi   = step[0];
            a.addr = step[0] ? frt_pkg::ADDR_CNT_HI : frt_pkg::ADDR_CNT_LO;
         end
         // capture detection off during the read
         frt_pkg::CMD_CAP_RD: begin
            a.last = (step == 2'd3);
            a.we   = (step == 2'd0) | (step == 2'd3);
            a.hi   = (step == 2'd2);
            a.addr = a.we ? frt_pkg::ADDR_MODE :
                     (a.hi ? frt_pkg::ADDR_CAP_HI : frt_pkg::ADDR_CAP_LO);
            a.data = (step == 2'd0) ? no_edge : sh;
         end
         frt_pkg::CMD_CMP_WR: begin
            a.last = (step == 2'd3);
            a.we   = 1'b1;
            a.addr = (step == 2'd1) ? frt_pkg::ADDR_CMP_LO :
                     (step == 2'd2) ? frt_pkg::ADDR_CMP_HI : frt_pkg::ADDR_MODE;
            a.data = (step == 2'd0) ? no_inv :
                     (step == 2'd1) ? wd[7:0] :
                     (step == 2'd2) ? wd[15:8] : sh;
         end
      endcase
      return a;
   endfunction : frt_step

   wire frt_acc_s acc       = frt_step(cmd_ff, step_ff, caddr_ff, cwdata_ff, shadow_ff);
   wire           acc_mode  = acc.we & (acc.addr == frt_pkg::ADDR_MODE);
   wire           plain_cmd = (cmd_ff == frt_pkg::CMD_WRITE);
   // overflow bit kept at one so a restore never clears the flag
   wire [7:0]     nxt_shadow = {1'b0, 1'b1, acc.data[5:0]};

   // ==========================================================================
   // sequencer
   // ==========================================================================
   always_ff @(posedge bus.i_clk_sys) begin
      if (!bus.i_resetn) begin
         st_ff      <= ST_IDLE;
         cmd_ff     <= frt_pkg::CMD_READ;
         caddr_ff   <= 16'h0000;
         cwdata_ff  <= 16'h0000;
         step_ff    <= 2'h0;
         shadow_ff  <= {1'b0, 1'b1, frt_pkg::MODE_RST[5:0]};
         addr_ff    <= 16'h0000;
         rd_ff      <= 1'b0;
         wr_ff      <= 1'b0;
         wdata_ff   <= 8'h00;
         o_busy     <= 1'b0;
         o_done     <= 1'b0;
         o_rdata    <= 16'h0000;
         o_irq_mask <= 1'b0;
         o_irq_seen <= 1'b0;
      end else begin
         o_done     <= 1'b0;
         o_irq_seen <= bus.match_irq;
         unique case (st_ff)
            ST_IDLE: begin
               if (i_cmd_valid) begin
                  cmd_ff    <= i_cmd;
                  caddr_ff  <= i_addr;
                  cwdata_ff <= i_wdata;
                  step_ff   <= 2'h0;
                  o_busy    <= 1'b1;
                  o_rdata   <= 16'h0000;
                  o_irq_mask <= (i_cmd == frt_pkg::CMD_CMP_WR);
                  st_ff     <= ST_ISSUE;
               end
            end
            ST_ISSUE: begin
               addr_ff  <= acc.addr;
               wdata_ff <= acc.data;
               rd_ff    <= ~acc.we;
               wr_ff    <= acc.we;
               // shadow follows every mode write except temporary ones
               if (acc_mode & (acc.last | plain_cmd)) begin
                  shadow_ff <= nxt_shadow;
               end
               st_ff    <= ST_STROBE;
            end
            ST_STROBE: begin
               rd_ff <= 1'b0;
               wr_ff <= 1'b0;
               st_ff <= ST_COLLECT;
            end
            ST_COLLECT: begin
               if (!acc.we) begin
                  if (acc.hi) begin
                     o_rdata[15:8] <= bus.rdata;
                  end else begin
                     o_rdata[7:0] <= bus.rdata;
                  end
               end
               if (acc.last) begin
                  o_busy     <= 1'b0;
                  o_done     <= 1'b1;
                  o_irq_mask <= 1'b0;
                  st_ff      <= ST_IDLE;
               end else begin
                  step_ff <= step_ff + 2'h1;
                  st_ff   <= ST_ISSUE;
               end
            end
         endcase
      end
   end

   assign bus.addr  = addr_ff;
   assign bus.rd    = rd_ff;
   assign bus.wr    = wr_ff;
   assign bus.wdata = wdata_ff;

endmodule : frt_cpu_host

// >>> verif/frt_props.sv
`timescale 1ns/1ps
module frt_props (
   // bus side
   input wire logic        i_clk_sys,
   input wire logic        i_resetn,
   input wire logic [15:0] addr,
   input wire logic        rd,
   input wire logic        wr,
   input wire logic [7:0]  wdata,
   input wire logic [7:0]  rdata,
   input wire logic        match_irq,
   // pins
   input wire logic        o_timer_output_pin,
   input wire logic        o_timer_output_pin_oe,
   // host side
   input wire logic        irq_mask
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_resetn);

   // ==========================================================================
   // shadow of the last mode write, reset mode has capture and invert off
   // ==========================================================================
   logic cap_off_ff;
   logic inv_off_ff;
   wire  mode_wr = wr && (addr == frt_pkg::ADDR_MODE);
   wire  cmp_wr  = wr && (addr[15:1] == frt_pkg::ADDR_CMP_LO[15:1]);
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         cap_off_ff <= 1'b1;
         inv_off_ff <= 1'b1;
      end else if (mode_wr) begin
         cap_off_ff <= (wdata[5:4] == 2'h0);
         inv_off_ff <= !wdata[3];
      end
   end

   // ==========================================================================
   // properties
   // ==========================================================================
   sequence s_cnt_lo;
      rd && (addr == frt_pkg::ADDR_CNT_LO);
   endsequence
   sequence s_cnt_hi;
      rd && (addr == frt_pkg::ADDR_CNT_HI);
   endsequence

   a_rd_wr_excl: assert property (!(rd && wr))
      else $error("read and write strobes together");
   a_rd_one_pulse: assert property (rd |=> !rd)
      else $error("read strobe longer than one cycle");
   a_irq_one_pulse: assert property (match_irq |=> !match_irq)
      else $error("match request longer than one cycle");
   a_cnt_read_pair: assert property (s_cnt_lo |-> ##[1:4] s_cnt_hi)
      else $error("counter low byte read not followed by high byte");
   a_out_level_bit: assert property ((rd && addr == frt_pkg::ADDR_MODE)
      |=> (!rdata[0] || (rdata[7] == o_timer_output_pin)))
      else $error("output level bit differs from enabled pin");
   a_dir_pin_oe: assert property ((rd && addr == frt_pkg::ADDR_PM2)
      |=> (o_timer_output_pin_oe == !rdata[4]))
      else $error("pin enable differs from direction bit");
   a_cap_read_off: assert property ((rd && addr == frt_pkg::ADDR_CAP_LO) |-> cap_off_ff)
      else $error("capture read with trigger detection enabled");
   a_cmp_inv_off: assert property (cmp_wr |-> inv_off_ff)
      else $error("compare rewrite with inversion enabled");
   a_cmp_wr_masked: assert property (cmp_wr |-> irq_mask)
      else $error("compare rewrite with match request unmasked");
endmodule : frt_props

// >>> verif/tb_free_running_timer_compare_capture.sv
`timescale 1ns/1ps
module tb_free_running_timer_compare_capture;
   logic              i_clk_sys;
   logic              i_resetn;
   logic              cmd_valid;
   frt_pkg::frt_cmd_e cmd;
   logic [15:0]       cmd_addr;
   logic [15:0]       cmd_wdata;
   logic              cap_pin;
   logic              pin4_latch;
   logic [15:0]       rd_val;
   logic [15:0]       t0;
   wire               busy;
   wire               done;
   wire  [15:0]       host_rdata;
   wire               irq_seen;
   wire               irq_mask;
   wire               tout;
   wire               tout_oe;
   int                mismatches;
   int                checked;

   frt_bus_if u_frt_bus_if (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn));
   frt_timer_dev u_frt_timer_dev (.bus(u_frt_bus_if), .i_capture_trigger_pin(cap_pin),
      .i_port2_pin4_latch(pin4_latch), .o_timer_output_pin(tout),
      .o_timer_output_pin_oe(tout_oe));
   frt_cpu_host u_frt_cpu_host (.bus(u_frt_bus_if), .i_cmd_valid(cmd_valid), .i_cmd(cmd),
      .i_addr(cmd_addr), .i_wdata(cmd_wdata), .o_busy(busy), .o_done(done),
      .o_rdata(host_rdata), .o_irq_mask(irq_mask), .o_irq_seen(irq_seen));
   frt_props u_frt_props (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
      .addr(u_frt_bus_if.addr), .rd(u_frt_bus_if.rd), .wr(u_frt_bus_if.wr),
      .wdata(u_frt_bus_if.wdata), .rdata(u_frt_bus_if.rdata),
      .match_irq(u_frt_bus_if.match_irq), .o_timer_output_pin(tout),
      .o_timer_output_pin_oe(tout_oe), .irq_mask(irq_mask));

   // ==========================================================================
   // tasks
   // ==========================================================================
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // accept spacing is fixed: next command is taken one cycle after done
   task automatic run(input frt_pkg::frt_cmd_e c, input logic [15:0] a, input logic [15:0] d);
      int n;
      n = 0;
      @(negedge i_clk_sys);
      cmd_valid = 1'b1;
      cmd = c;
      cmd_addr = a;
      cmd_wdata = d;
      @(negedge i_clk_sys);
      cmd_valid = 1'b0;
      do begin
         @(posedge i_clk_sys);
         #1;
         n++;
      end while (done !== 1'b1 && n < 40);
      chk({15'h0000, done}, 16'h0001);
      chk({15'h0000, busy}, 16'h0000);
      rd_val = host_rdata;
   endtask : run

   task automatic results();
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : results

   // ==========================================================================
   // clock, watchdog, tests
   // ==========================================================================
   initial begin
      i_clk_sys = 1'b0;
      forever #2.5 i_clk_sys = ~i_clk_sys;
   end

   initial begin
      repeat (20000) @(posedge i_clk_sys);
      mismatches++;
      results();
   end

   initial begin
      i_resetn = 1'b0;
      cmd_valid = 1'b0;
      cmd = frt_pkg::CMD_READ;
      cmd_addr = 16'h0000;
      cmd_wdata = 16'h0000;
      cap_pin = 1'b0;
      pin4_latch = 1'b0;
      mismatches = 0;
      checked = 0;
      repeat (6) @(negedge i_clk_sys);
      i_resetn = 1'b1;
      run(frt_pkg::CMD_CNT_RD, 16'h0000, 16'h0000);
      chk(16'(rd_val < 16'h0010), 16'h0001);
      run(frt_pkg::CMD_READ, frt_pkg::ADDR_PM2, 16'h0000);
      chk(rd_val, 16'h00ff);
      run(frt_pkg::CMD_READ, frt_pkg::ADDR_CMP_LO, 16'h0000);
      chk(rd_val, 16'h00ff);
      run(frt_pkg::CMD_READ, frt_pkg::ADDR_CMP_HI, 16'h0000);
      chk(rd_val, 16'h00ff);
      chk({15'h0000, tout_oe}, 16'h0000);
      run(frt_pkg::CMD_WRITE, frt_pkg::ADDR_MODE, 16'h00c0);
      run(frt_pkg::CMD_READ, frt_pkg::ADDR_MODE, 16'h0000);
      chk(rd_val, 16'h0000);
      // ========================================================================
      // clock select: two reads 640 cycles apart, a multiple of both dividers
      // ========================================================================
      for (int s = 0; s < 4; s++) begin
         run(frt_pkg::CMD_WRITE, frt_pkg::ADDR_MODE, 16'(s << 1));
         run(frt_pkg::CMD_CNT_RD, 16'h0000, 16'h0000);
         t0 = rd_val;
         repeat (633) @(negedge i_clk_sys);
         run(frt_pkg::CMD_CNT_RD, 16'h0000, 16'h0000);
         chk(rd_val - t0, (s == 0) ? 16'h00a0 : ((s == 1) ? 16'h000a : 16'h0000));
      end
      run(frt_pkg::CMD_WRITE, frt_pkg::ADDR_PM2, 16'h00ef);
      pin4_latch = 1'b1;
      repeat (3) @(negedge i_clk_sys);
      chk({15'h0000, tout_oe}, 16'h0001);
      chk({15'h0000, tout}, 16'h0001);
      pin4_latch = 1'b0;
      // ========================================================================
      // compare match with inversion and pin output
      // ========================================================================
      run(frt_pkg::CMD_WRITE, frt_pkg::ADDR_MODE, 16'h0009);
      run(frt_pkg::CMD_CNT_RD, 16'h0000, 16'h0000);
      t0 = rd_val + 16'h0028;
      run(frt_pkg::CMD_CMP_WR, 16'h0000, t0);
      chk({15'h0000, tout}, 16'h0000);
      for (int n = 0; n < 400 && irq_seen !== 1'b1; n++) begin
         @(posedge i_clk_sys);
         #1;
      end
      chk({15'h0000, irq_seen}, 16'h0001);
      repeat (3) @(negedge i_clk_sys);
      chk({15'h0000, tout}, 16'h0001);
      run(frt_pkg::CMD_READ, frt_pkg::ADDR_MODE, 16'h0000);
      chk({15'h0000, rd_val[7]}, 16'h0001);
      run(frt_pkg::CMD_CNT_RD, 16'h0000, 16'h0000);
      chk(16'(rd_val > t0), 16'h0001);
      // ========================================================================
      // capture edge codes: a capture shows as a changed captured value
      // ========================================================================
      for (int e = 0; e < 4; e++) begin
         run(frt_pkg::CMD_WRITE, frt_pkg::ADDR_MODE, 16'(e << 4));
         run(frt_pkg::CMD_CAP_RD, 16'h0000, 16'h0000);
         t0 = rd_val;
         cap_pin = 1'b1;
         repeat (40) @(negedge i_clk_sys);
         run(frt_pkg::CMD_CAP_RD, 16'h0000, 16'h0000);
         chk(16'(rd_val !== t0), 16'(e[0]));
         t0 = rd_val;
         cap_pin = 1'b0;
         repeat (40) @(negedge i_clk_sys);
         run(frt_pkg::CMD_CAP_RD, 16'h0000, 16'h0000);
         chk(16'(rd_val !== t0), 16'(e[1]));
      end
      results();
   end
endmodule : tb_free_running_timer_compare_capture
